// file: core/wdt_pkg.sv
//==============================================================
// Behaviour
// - Debug-stop bit: free in special modes, otherwise set-only.
// - Outside special modes window and rate accept one write only.
// - Period restarts on accepted nonzero rate or debug-stop rising.
// - Window mode: arm writes in first 75% of period reset.
// - Write-mask bit is write-only; masked writes keep window and rate, but still write debug-stop (a rise restarts count).
// - Debug-stop set halts counters while background debug is active.
// - Nonzero rate enables counter; time-out requests system reset.
// - Debug active, stop clear, emulation/special: longest period, normal mode.
// - Rate 000 off; 001..111 give 2^14,16,18,20,22,23,24 cycles.
// - Time-out counted from last restart: reset, accepted nonzero rate, debug-stop rise or completed arm pair.
// - Factory test registers read zero outside special modes, writable inside.
// - Arm register reads zero; writes ignored while rate is 000.
// - Enabled: arm values other than 0x55/0xAA reset; 0x55 then 0xAA restarts.
// - Repeated first or second values tolerated; restart needs second after first.
// - Window mode: repeated first value allowed in window; pair restarts.
package wdt_pkg;
  //==============================================================
  // Register map
  localparam logic [3:0] ADDR_CONTROL     = 4'h8;
  localparam logic [3:0] ADDR_BYPASS      = 4'h9;
  localparam logic [3:0] ADDR_TEST        = 4'hA;
  localparam logic [3:0] ADDR_ARM         = 4'hB;
  // Control register fields
  localparam int         BIT_WINDOW       = 7;
  localparam int         BIT_DEBUG_STOP   = 6;
  localparam int         BIT_WRITE_MASK   = 5;
  localparam int         RATE_LSB         = 0;
  localparam logic [2:0] RATE_OFF         = 3'h0;
  localparam logic [2:0] RATE_LONGEST     = 3'h7;
  // Reset values
  localparam logic [7:0] CONTROL_RESET    = 8'h00;
  localparam logic [7:0] TEST_RESET       = 8'h00;
  // Arm sequence values
  localparam logic [7:0] ARM_FIRST        = 8'h55;
  localparam logic [7:0] ARM_SECOND       = 8'hAA;
  // Counter width, enough for 2^24 cycles
  localparam int         CNT_W            = 24;
endpackage

// file: core/wdt_period_if.sv
`timescale 1ns/10ps
// Period selection travelling from control to counter decode
interface wdt_period_if;
  logic [2:0]  rate;
  logic [23:0] count;
  logic        in_window;
  modport ctrl (output rate, input count, in_window);
  modport dec  (input rate, count, output in_window);
endinterface

// file: core/wdt_period_decode.sv
`timescale 1ns/10ps
module wdt_period_decode
  import wdt_pkg::*;
(
  wdt_period_if.dec p
);
  logic [CNT_W-1:0] limits [8];
  logic [CNT_W-1:0] limit;
  //==============================================================
  // Terminal counts per rate
  assign limits[0] = '0;
  assign limits[1] = 24'h003FFF;
  assign limits[2] = 24'h00FFFF;
  assign limits[3] = 24'h03FFFF;
  assign limits[4] = 24'h0FFFFF;
  assign limits[5] = 24'h3FFFFF;
  assign limits[6] = 24'h7FFFFF;
  assign limits[7] = 24'hFFFFFF;
  assign limit = limits[p.rate];
  // Last quarter: count at or past three quarters of the period
  assign p.in_window = ({2'h0, p.count} >= ({2'h0, limit} + 26'h1) - (({2'h0, limit} + 26'h1) >> 2));
endmodule // wdt_period_decode

// file: core/windowed_watchdog_timer.sv
`timescale 1ns/10ps
module windowed_watchdog_timer
  import wdt_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       special_mode,
  input  wire logic       emulation_mode,
  input  wire logic       debug_active,
  output logic            tick_halt,
  output logic            reset_req
);
  logic             window_enable;
  logic             debug_stop;
  logic [2:0]       rate_select;
  logic             written_once;
  logic [7:0]       factory_bypass;
  logic [7:0]       factory_test_control;
  logic             armed_first;
  logic [CNT_W-1:0] count;
  wdt_period_if     per ();

  //==============================================================
  // Decode
  wire wr_ctrl   = wr && addr == ADDR_CONTROL;
  wire wr_arm    = wr && addr == ADDR_ARM;
  wire wr_byp    = wr && addr == ADDR_BYPASS && special_mode;
  wire wr_test   = wr && addr == ADDR_TEST && special_mode;
  wire masked    = wdata[BIT_WRITE_MASK];
  wire field_ok  = wr_ctrl && !masked && (special_mode || !written_once);
  wire [2:0] wr_rate = wdata[RATE_LSB+:3];
  // Outside special modes a zero rate or clear window is ignored
  wire next_rate_take = field_ok && (special_mode || wr_rate != RATE_OFF);
  wire next_win_take  = field_ok && (special_mode || wdata[BIT_WINDOW]);
  wire stop_ok   = wr_ctrl && (special_mode || wdata[BIT_DEBUG_STOP]);
  wire stop_rise = stop_ok && !debug_stop && wdata[BIT_DEBUG_STOP];
  wire enabled   = rate_select != RATE_OFF;
  // Debug override forces longest period in normal mode
  wire override  = enabled && debug_active && !debug_stop
                   && (emulation_mode || special_mode);
  wire halted    = debug_stop && debug_active;
  wire win_mode  = window_enable && !override;
  assign per.rate = override ? RATE_LONGEST : rate_select;
  assign per.count = count;
  // Terminal count of the selected period
  wire at_limit  = (per.rate == 3'h1) ? &count[13:0] : (per.rate == 3'h2) ? &count[15:0] :
                   (per.rate == 3'h3) ? &count[17:0] : (per.rate == 3'h4) ? &count[19:0] :
                   (per.rate == 3'h5) ? &count[21:0] : (per.rate == 3'h6) ? &count[22:0] :
                   &count[23:0];
  wire expired   = enabled && !halted && at_limit;
  wire arm_live  = wr_arm && enabled;
  wire bad_value = arm_live && wdata != ARM_FIRST && wdata != ARM_SECOND;
  wire early     = arm_live && win_mode && !per.in_window;
  wire arm_done  = arm_live && !bad_value && !early
                   && wdata == ARM_SECOND && armed_first;
  wire fire      = expired || bad_value || early;
  wire restart   = (next_rate_take && wr_rate != RATE_OFF) || stop_rise || arm_done;

  wdt_period_decode u_dec (
    .p (per.dec)
  );

  //==============================================================
  // Control register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      window_enable <= CONTROL_RESET[BIT_WINDOW];
      debug_stop    <= CONTROL_RESET[BIT_DEBUG_STOP];
      rate_select   <= CONTROL_RESET[RATE_LSB+:3];
      written_once  <= 1'b0;
    end else begin
      if (next_win_take) window_enable <= wdata[BIT_WINDOW];
      if (next_rate_take) rate_select <= wr_rate;
      if (stop_ok) debug_stop <= wdata[BIT_DEBUG_STOP];
      if (field_ok) written_once <= 1'b1;
    end
  end

  //==============================================================
  // Factory test registers, special modes only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      factory_bypass       <= TEST_RESET;
      factory_test_control <= TEST_RESET;
    end else begin
      if (wr_byp) factory_bypass <= wdata;
      if (wr_test) factory_test_control <= wdata;
    end
  end

  //==============================================================
  // Arm sequence; repeated first value keeps the pair open
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      armed_first <= 1'b0;
    end else if (restart || fire) begin
      armed_first <= 1'b0;
    end else if (arm_live && wdata == ARM_FIRST) begin
      armed_first <= 1'b1;
    end
  end

  //==============================================================
  // Time-out counter; a reset request starts it afresh too
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else if (restart || fire || !enabled) begin
      count <= '0;
    end else if (!halted) begin
      count <= count + 24'h1;
    end
  end

  //==============================================================
  // Read data and outputs, all registered
  wire [7:0] ctrl_view = {window_enable, debug_stop, 3'h0, rate_select};
  wire [7:0] next_rdata = !rd ? 8'h00 :
                          addr == ADDR_CONTROL ? ctrl_view :
                          addr == ADDR_BYPASS && special_mode ? factory_bypass :
                          addr == ADDR_TEST && special_mode ? factory_test_control :
                          8'h00;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata     <= 8'h00;
      reset_req <= 1'b0;
      tick_halt <= 1'b0;
    end else begin
      rdata     <= next_rdata;
      reset_req <= fire;
      tick_halt <= halted;
    end
  end
endmodule // windowed_watchdog_timer

// file: verif/windowed_watchdog_timer_sva.sv
`timescale 1ns/10ps
//==========================================
// Port-level checks of the watchdog
module windowed_watchdog_timer_sva
  import wdt_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       special_mode,
  input wire logic       emulation_mode,
  input wire logic       debug_active,
  input wire logic       tick_halt,
  input wire logic       reset_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // No control write yet means disabled, so no reset can be due
  logic ctl_seen;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) ctl_seen <= 1'b0;
    else if (wr && addr == ADDR_CONTROL) ctl_seen <= 1'b1;
  end
  property p_pulse; reset_req |=> !reset_req; endproperty
  a_pulse: assert property (p_pulse) else $error("reset request too long");
  property p_idle; !ctl_seen |-> !reset_req; endproperty
  a_idle: assert property (p_idle) else $error("reset while disabled");
  property p_arm_rd; rd && addr == ADDR_ARM |=> rdata == 8'h00; endproperty
  a_arm_rd: assert property (p_arm_rd) else $error("arm read not zero");
  property p_test_rd; rd && addr == ADDR_TEST && !special_mode |=> rdata == 8'h00; endproperty
  a_test_rd: assert property (p_test_rd) else $error("test read not zero");
  property p_byp_rd; rd && addr == ADDR_BYPASS && !special_mode |=> rdata == 8'h00; endproperty
  a_byp_rd: assert property (p_byp_rd) else $error("bypass read not zero");
  property p_mask_rd; rd && addr == ADDR_CONTROL |=> !rdata[BIT_WRITE_MASK]; endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("write mask read back");
  property p_halt_off; !debug_active |=> !tick_halt; endproperty
  a_halt_off: assert property (p_halt_off) else $error("halt without debug");
  property p_halt_on; $rose(tick_halt) |-> $past(debug_active); endproperty
  a_halt_on: assert property (p_halt_on) else $error("halt rose without cause");
  // Main scenarios reached
  cover property (reset_req);
  cover property (tick_halt);
  cover property (wr && addr == ADDR_ARM && wdata == ARM_SECOND);
endmodule // windowed_watchdog_timer_sva

bind windowed_watchdog_timer windowed_watchdog_timer_sva u_sva (.core_clk(core_clk),
  .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .special_mode(special_mode), .emulation_mode(emulation_mode),
  .debug_active(debug_active), .tick_halt(tick_halt), .reset_req(reset_req));

// file: verif/windowed_watchdog_timer_test.sv
`timescale 1ns/10ps
//==========================================
// Register-level bench of the watchdog
module windowed_watchdog_timer_test
  import wdt_pkg::*;
;
  logic       core_clk = 1'b0;
  logic       nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       special_mode = 1'b0;
  logic       emulation_mode = 1'b0;
  logic       debug_active = 1'b0;
  logic [7:0] rdata;
  logic       tick_halt;
  logic       reset_req;
  int         error_cnt = 0;
  int         num_checks = 0;
  int         req_cnt = 0;
  always #25 core_clk = ~core_clk;
  // Counted on the falling edge, where the pulse has settled
  always @(negedge core_clk) if (reset_req === 1'b1) req_cnt++;
  windowed_watchdog_timer DUT (.core_clk(core_clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .special_mode(special_mode),
    .emulation_mode(emulation_mode), .debug_active(debug_active),
    .tick_halt(tick_halt), .reset_req(reset_req));
  //==========================================
  // Bus tasks and comparison
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    check("rdata", {24'h0, e}, {24'h0, rdata});
  endtask
  // Bounded wait for a reset pulse; its arrival cycle must fall in lo..hi
  task automatic wait_req(input int lo, input int hi);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (reset_req !== 1'b1 && n < hi);
    check("reset_req", 1, {31'h0, reset_req === 1'b1 && n >= lo});
    if (reset_req !== 1'b1) tally_and_finish();
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  //==========================================
  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    wr_reg(ADDR_ARM, 8'h12);
    rd_chk(ADDR_ARM, 8'h00);
    wr_reg(ADDR_CONTROL, 8'h21);
    rd_chk(ADDR_CONTROL, CONTROL_RESET);
    wr_reg(ADDR_CONTROL, 8'h01);
    rd_chk(ADDR_CONTROL, 8'h01);
    wr_reg(ADDR_CONTROL, 8'hC7);
    rd_chk(ADDR_CONTROL, 8'h41);
    wr_reg(ADDR_CONTROL, 8'h00);
    rd_chk(ADDR_CONTROL, 8'h41);
    wr_reg(ADDR_BYPASS, 8'h5A);
    rd_chk(ADDR_BYPASS, 8'h00);
    wr_reg(ADDR_TEST, 8'h5A);
    rd_chk(ADDR_TEST, 8'h00);
    @(posedge core_clk);
    debug_active <= 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    check("tick_halt", 1, {31'h0, tick_halt});
    @(posedge core_clk);
    debug_active <= 1'b0;
    // Repeats of either value must be harmless
    wr_reg(ADDR_ARM, ARM_FIRST);
    wr_reg(ADDR_ARM, ARM_FIRST);
    wr_reg(ADDR_ARM, ARM_SECOND);
    wr_reg(ADDR_ARM, ARM_SECOND);
    repeat (2) @(posedge core_clk);
    check("req_cnt", 0, req_cnt);
    wr_reg(ADDR_ARM, 8'h12);
    wait_req(1, 2);
    wait_req(16380, 16390);
    repeat (2) @(posedge core_clk);
    check("req_cnt", 2, req_cnt);
    special_mode <= 1'b1;
    wr_reg(ADDR_TEST, 8'h5A);
    rd_chk(ADDR_TEST, 8'h5A);
    wr_reg(ADDR_CONTROL, 8'h81);
    wr_reg(ADDR_ARM, ARM_FIRST);
    wait_req(1, 2);
    // Past three quarters of 2^14 the window is open
    repeat (12400) @(posedge core_clk);
    wr_reg(ADDR_ARM, ARM_FIRST);
    wr_reg(ADDR_ARM, ARM_SECOND);
    repeat (2) @(posedge core_clk);
    check("req_cnt", 3, req_cnt);
    // Debug override drops window mode, so an early pair is accepted
    debug_active <= 1'b1;
    emulation_mode <= 1'b1;
    wr_reg(ADDR_ARM, ARM_FIRST);
    wr_reg(ADDR_ARM, ARM_SECOND);
    repeat (2) @(posedge core_clk);
    check("req_cnt", 3, req_cnt);
    debug_active <= 1'b0;
    emulation_mode <= 1'b0;
    tally_and_finish();
  end
endmodule // windowed_watchdog_timer_test
